// *** src/fosr_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the fault
// output and reset block. Included by the package and by the top module.
`ifndef FOSR_CONSTS_SVH
`define FOSR_CONSTS_SVH
`define FOSR_A_FLAG_LO 8'h1B
`define FOSR_A_FLAG_HI 8'h1C
`define FOSR_A_SLOT 8'h1D
`define FOSR_A_STATUS 8'h1E
`define FOSR_A_FA_LO 8'h36
`define FOSR_A_FA_HI 8'h37
`define FOSR_A_FB_LO 8'h38
`define FOSR_A_FB_HI 8'h39
`define FOSR_A_OC_SEL 8'h3A
`define FOSR_A_RST_CFG 8'h3B
`define FOSR_A_RST_SEL_LO 8'h3C
`define FOSR_A_RST_SEL_HI 8'h3D
`define FOSR_A_PIN_TYPE 8'h42
`define FOSR_A_LOG_CFG 8'h6D
`define FOSR_A_CRIT_LO 8'h6E
`define FOSR_A_CRIT_HI 8'h6F
`define FOSR_A_CRIT_EXT 8'h72
`define FOSR_A_DG_OC 8'h73
`define FOSR_A_DG_V 8'h74
`define FOSR_A_LOG_LOCK 8'h8C
`define FOSR_B_OV_EN 4
`define FOSR_B_UV_EN 5
`define FOSR_B_EW_EN 6
`define FOSR_B_POL 7
`define FOSR_B_OC_A 0
`define FOSR_B_OC_B 1
`define FOSR_B_FORCE 0
`define FOSR_B_EXT_EN 5
`define FOSR_B_EXT_LOG 2
`define FOSR_B_OC_FLAG 4
`define FOSR_B_EXT_FLAG 5
`define FOSR_B_ALERT_FLAG 7
`define FOSR_B_OC_CRIT 4
`define FOSR_B_RST2_PIN 1
`define FOSR_B_EXT_PIN 3
`define FOSR_LOG_OFF 2'h3
`define FOSR_REG_RESET 8'h00
`define FOSR_CLK_MHZ 100
`define FOSR_OC_DG1_MS 4
`define FOSR_OC_DG2_MS 15
`define FOSR_OC_DG3_MS 60
`define FOSR_RST_TMO_BASE_US 25
`define FOSR_MS_TO_CYC(ms) ((ms) * `FOSR_CLK_MHZ * 1000)
`define FOSR_US_TO_CYC(us) ((us) * `FOSR_CLK_MHZ)
`endif

// *** src/fosr_pkg.sv ***
// Types shared by the fault output and reset block and its bench.
// Assumes the constants header sits beside it on the include path.
package fosr_pkg;
   `include "fosr_consts.svh"

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } fosr_bus_type;

   typedef struct packed {
      logic valid;
      logic [3:0] ch;
      logic [9:0] result;
      logic [7:0] ov_lim;
      logic [7:0] uv_lim;
      logic [7:0] ew_lim;
      logic ew_is_ov;
   } fosr_conv_type;

   typedef struct packed {
      logic [7:0] fa_lo, fa_hi, fb_lo, fb_hi, oc_sel;
      logic [7:0] rst_cfg, rst_sel_lo, rst_sel_hi, pin_type;
      logic [7:0] log_cfg, crit_lo, crit_hi, crit_ext, dg_oc, dg_v;
      logic [7:0] flag_lo, flag_hi, slot, rdata;
      logic [11:0] ov_st, uv_st, ew_st;
      logic [3:0] dg_ch;
      logic [4:0] dg_cnt;
      logic [31:0] oc_cnt;
      logic oc_st;
      logic [31:0] rst_tmr, rst2_tmr;
      logic ext_prev;
      logic log_lock;
      logic log_go;
   } fosr_state_type;
endpackage : fosr_pkg

// *** src/fosr_top.sv ***
// Fault detection, fault pin drive, reset outputs and fault flags of a supply monitor.
// Assumes a converter feeding one result per valid pulse, a sequencer that reports its
// secondary group state, and register access over a simple strobe port.
// How it works
// - Fault B upper select bits 0-3 add monitors 9-12 to fault B.
// - Fault B bits 4-6 enable overvoltage, undervoltage and early-warning causes.
// - Fault B bit 7 picks polarity: zero active-low, one active-high.
// - Overcurrent select bit 0 feeds fault A, bit 1 feeds fault B.
// - Overcurrent alarm drives low while the primary comparator trips.
// - Secondary-sequence limit faults drive the sequence fault indicator and fault request.
// - Manual reset low holds resets, then one timeout after release.
// - Secondary reset holds through sequencing until slot twelve completes plus timeout.
// - Chosen monitors violating chosen threshold types assert the secondary reset.
// - Critical secondary-group monitors over or under their limits always assert the secondary reset; early warning does not.
// - Secondary reset is active-low, push-pull or open-drain by pin type bit.
// - Shared timeout code; force bit asserts both resets, then one timeout.
// - Watchdog timeout output is active-low; kick input passes through.
// - External fault line driven on critical fault, or pulled low externally.
// - Enabled external fault low requests sequencer fault and sets its flag.
// - With logging enabled too, external fault falling starts a fault log.
// - Compare upper eight result bits; skip disabled monitors.
// - Critical fault starts one log and sets the protecting lock.
// - Out-of-limit holds the channel; fault only after consecutive count.
// - Flags other than the alert flag need their critical enable; fault pins ignore those enables.
// - Flags readable any time and cleared by writing one.
// - Secondary-group fault stores its slot number.
// - Combined fault output drives low on any monitor, fault pin, secondary overcurrent or sequence fault, not on external fault.
// - Voltage deglitch codes select 2, 4, 8 or 16 consecutive results.
`timescale 1ns/1ps
`include "fosr_consts.svh"
module fosr_top #(
   parameter int unsigned OC_DG1_CYC = `FOSR_MS_TO_CYC(`FOSR_OC_DG1_MS),
   parameter int unsigned OC_DG2_CYC = `FOSR_MS_TO_CYC(`FOSR_OC_DG2_MS),
   parameter int unsigned OC_DG3_CYC = `FOSR_MS_TO_CYC(`FOSR_OC_DG3_MS),
   parameter int unsigned RST_TMO_BASE_CYC = `FOSR_US_TO_CYC(`FOSR_RST_TMO_BASE_US)
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire fosr_pkg::fosr_bus_type bus,
   output logic [7:0] rdata,
   input wire fosr_pkg::fosr_conv_type conv,
   input wire logic [11:0] monitor_input_en,
   output logic hold_channel,
   input wire logic primary_oc_cmp,
   input wire logic secondary_oc_cmp,
   input wire logic seq2_active,
   input wire logic [3:0] seq2_slot,
   input wire logic [11:0] seq2_mask,
   input wire logic [11:0] slot12_mask,
   input wire logic slot12_delay_done,
   input wire logic manual_reset_input_b,
   input wire logic watchdog_expired,
   input wire logic watchdog_kick_input,
   output logic watchdog_kick,
   output logic watchdog_timeout_output_b,
   input wire logic alert_event,
   input wire logic log_unlock,
   output logic fault_output_a,
   output logic fault_output_b,
   output logic any_fault_b,
   output logic overcurrent_alarm_b,
   output logic sequence_fault_indicator_b,
   output logic reset_output_b,
   output logic secondary_reset_output_o,
   output logic secondary_reset_output_oe,
   input wire logic external_fault_line_i,
   output logic external_fault_line_o,
   output logic external_fault_line_oe,
   output logic seq_fault_req,
   output logic log_start,
   output logic [1:0] log_mode,
   output logic log_locked
);
   import fosr_pkg::*;

   fosr_state_type st_q, st_d;

   // Combined fault cause of one fault output from its select and type bits.
   function automatic logic fault_cause(input logic [7:0] lo, input logic [7:0] hi,
                                        input logic [11:0] ov, input logic [11:0] uv,
                                        input logic [11:0] ew);
      logic [11:0] sel;
      sel = {hi[3:0], lo};
      fault_cause = (hi[`FOSR_B_OV_EN] && |(sel & ov)) ||
                    (hi[`FOSR_B_UV_EN] && |(sel & uv)) ||
                    (hi[`FOSR_B_EW_EN] && |(sel & ew));
   endfunction : fault_cause

   logic fa_act, fb_act, any_st, seq2_flt, crit_flt, ext_low, ext_od;
   logic rst_cause, rst2_cause, rst2_sel_viol, seq2_done;
   logic [11:0] rst_sel, crit_mask, declare_ov, declare_uv, declare_ew, declared;
   logic [11:0] set_mon;
   logic [7:0] set_lo, set_hi, cmp_res;
   logic [4:0] dg_need;
   logic [31:0] oc_need, tmo_cyc;
   logic conv_ok, v_ov, v_uv, v_ew, v_any, oc_rise;

   always_comb begin
      st_d = st_q;
      declare_ov = '0;
      declare_uv = '0;
      declare_ew = '0;
      // Only the upper eight bits take part; the low bits are converter noise here.
      cmp_res = conv.result[9:2];
      conv_ok = conv.valid && (conv.ch < 4'hC) && monitor_input_en[conv.ch];
      v_ov = cmp_res > conv.ov_lim;
      v_uv = cmp_res < conv.uv_lim;
      v_ew = conv.ew_is_ov ? (cmp_res > conv.ew_lim) : (cmp_res < conv.ew_lim);
      v_any = v_ov || v_uv || v_ew;
      dg_need = 5'h02 << st_q.dg_v[6:5];
      if (conv_ok) begin
         if (v_any) begin
            // A different channel restarts the run; the mux is meant to stay put.
            if (st_q.dg_cnt != 5'h00 && st_q.dg_ch == conv.ch) begin
               if (st_q.dg_cnt != dg_need) begin
                  st_d.dg_cnt = st_q.dg_cnt + 5'h01;
               end
            end else begin
               st_d.dg_cnt = 5'h01;
               st_d.dg_ch = conv.ch;
            end
            if (st_d.dg_cnt == dg_need) begin
               declare_ov[conv.ch] = v_ov;
               declare_uv[conv.ch] = v_uv;
               declare_ew[conv.ch] = v_ew;
               st_d.ov_st[conv.ch] = v_ov;
               st_d.uv_st[conv.ch] = v_uv;
               st_d.ew_st[conv.ch] = v_ew;
            end
         end else begin
            st_d.dg_cnt = 5'h00;
            st_d.ov_st[conv.ch] = 1'b0;
            st_d.uv_st[conv.ch] = 1'b0;
            st_d.ew_st[conv.ch] = 1'b0;
         end
      end
      declared = declare_ov | declare_uv | declare_ew;

      unique case (st_q.dg_oc[6:5])
         2'h0: oc_need = 32'h0000_0000;
         2'h1: oc_need = OC_DG1_CYC;
         2'h2: oc_need = OC_DG2_CYC;
         2'h3: oc_need = OC_DG3_CYC;
      endcase
      if (!secondary_oc_cmp) begin
         st_d.oc_cnt = '0;
         st_d.oc_st = 1'b0;
      end else if (st_q.oc_cnt >= oc_need) begin
         st_d.oc_st = 1'b1;
      end else begin
         st_d.oc_cnt = st_q.oc_cnt + 32'h0000_0001;
      end
      oc_rise = st_d.oc_st && !st_q.oc_st;

      // Fault pins look at raw status, never at the critical enables.
      fa_act = fault_cause(st_q.fa_lo, st_q.fa_hi, st_q.ov_st, st_q.uv_st, st_q.ew_st) ||
               (st_q.oc_sel[`FOSR_B_OC_A] && st_q.oc_st);
      fb_act = fault_cause(st_q.fb_lo, st_q.fb_hi, st_q.ov_st, st_q.uv_st, st_q.ew_st) ||
               (st_q.oc_sel[`FOSR_B_OC_B] && st_q.oc_st);
      any_st = |(st_q.ov_st | st_q.uv_st | st_q.ew_st);
      seq2_flt = seq2_active && |(seq2_mask & (st_q.ov_st | st_q.uv_st));

      ext_od = st_q.pin_type[`FOSR_B_EXT_PIN];
      ext_low = ext_od && !external_fault_line_i && st_q.crit_ext[`FOSR_B_EXT_EN];
      crit_mask = {st_q.crit_hi[3:0], st_q.crit_lo};
      crit_flt = |(declared & (crit_mask | (seq2_active ? seq2_mask : 12'h000))) ||
                 (oc_rise && st_q.crit_hi[`FOSR_B_OC_CRIT]) ||
                 (ext_low && !st_q.ext_prev);
      st_d.ext_prev = ext_low;

      // Set always beats a clearing write in the same cycle.
      set_mon = declared & crit_mask;
      set_lo = set_mon[7:0];
      set_hi = {alert_event, 1'b0, ext_low, oc_rise && st_q.crit_hi[`FOSR_B_OC_CRIT],
                set_mon[11:8]};
      if (bus.we && bus.addr == `FOSR_A_FLAG_LO) begin
         st_d.flag_lo = st_q.flag_lo & ~bus.wdata;
      end
      if (bus.we && bus.addr == `FOSR_A_FLAG_HI) begin
         st_d.flag_hi = st_q.flag_hi & ~bus.wdata;
      end
      st_d.flag_lo = st_d.flag_lo | set_lo;
      st_d.flag_hi = st_d.flag_hi | set_hi;
      if (seq2_active && |(declared & seq2_mask)) begin
         st_d.slot = {4'h0, seq2_slot};
      end

      // One log per lock; software must unlock before another is taken.
      st_d.log_go = 1'b0;
      if (log_unlock) begin
         st_d.log_lock = 1'b0;
      end
      if (crit_flt && !st_q.log_lock && st_q.log_cfg[1:0] != `FOSR_LOG_OFF) begin
         if (!(ext_low && !st_q.ext_prev) || st_q.log_cfg[`FOSR_B_EXT_LOG]) begin
            st_d.log_go = 1'b1;
            st_d.log_lock = 1'b1;
         end
      end

      tmo_cyc = RST_TMO_BASE_CYC << st_q.rst_cfg[7:4];
      rst_sel = {st_q.rst_sel_hi[4:0], st_q.rst_sel_lo[7:1]};
      unique case (st_q.rst_cfg[1:0])
         2'h0: rst2_sel_viol = |(rst_sel & st_q.uv_st);
         2'h1: rst2_sel_viol = |(rst_sel & st_q.ov_st);
         2'h2: rst2_sel_viol = |(rst_sel & (st_q.uv_st | st_q.ov_st));
         2'h3: rst2_sel_viol = |(rst_sel & st_q.ew_st);
      endcase
      seq2_done = slot12_delay_done && !(|(slot12_mask & st_q.uv_st));
      rst_cause = !manual_reset_input_b || st_q.rst_sel_lo[`FOSR_B_FORCE];
      rst2_cause = rst_cause || seq2_active || !seq2_done || rst2_sel_viol ||
                   |(seq2_mask & crit_mask & (st_q.ov_st | st_q.uv_st));
      if (rst_cause) begin
         st_d.rst_tmr = tmo_cyc;
      end else if (st_q.rst_tmr != 32'h0000_0000) begin
         st_d.rst_tmr = st_q.rst_tmr - 32'h0000_0001;
      end
      if (rst2_cause) begin
         st_d.rst2_tmr = tmo_cyc;
      end else if (st_q.rst2_tmr != 32'h0000_0000) begin
         st_d.rst2_tmr = st_q.rst2_tmr - 32'h0000_0001;
      end

      if (bus.we) begin
         case (bus.addr)
            `FOSR_A_FA_LO: st_d.fa_lo = bus.wdata;
            `FOSR_A_FA_HI: st_d.fa_hi = bus.wdata;
            `FOSR_A_FB_LO: st_d.fb_lo = bus.wdata;
            `FOSR_A_FB_HI: st_d.fb_hi = bus.wdata;
            `FOSR_A_OC_SEL: st_d.oc_sel = {6'h00, bus.wdata[1:0]};
            `FOSR_A_RST_CFG: st_d.rst_cfg = bus.wdata;
            `FOSR_A_RST_SEL_LO: st_d.rst_sel_lo = bus.wdata;
            `FOSR_A_RST_SEL_HI: st_d.rst_sel_hi = bus.wdata;
            `FOSR_A_PIN_TYPE: st_d.pin_type = bus.wdata;
            `FOSR_A_LOG_CFG: st_d.log_cfg = bus.wdata;
            `FOSR_A_CRIT_LO: st_d.crit_lo = bus.wdata;
            `FOSR_A_CRIT_HI: st_d.crit_hi = bus.wdata;
            `FOSR_A_CRIT_EXT: st_d.crit_ext = bus.wdata;
            `FOSR_A_DG_OC: st_d.dg_oc = bus.wdata;
            `FOSR_A_DG_V: st_d.dg_v = bus.wdata;
            default: ;
         endcase
      end
      st_d.rdata = 8'h00;
      if (bus.re) begin
         case (bus.addr)
            `FOSR_A_FLAG_LO: st_d.rdata = st_q.flag_lo;
            `FOSR_A_FLAG_HI: st_d.rdata = st_q.flag_hi;
            `FOSR_A_SLOT: st_d.rdata = st_q.slot;
            `FOSR_A_STATUS: st_d.rdata = {3'h0, st_q.log_lock, st_q.oc_st, any_st,
                                          fb_act, fa_act};
            `FOSR_A_FA_LO: st_d.rdata = st_q.fa_lo;
            `FOSR_A_FA_HI: st_d.rdata = st_q.fa_hi;
            `FOSR_A_FB_LO: st_d.rdata = st_q.fb_lo;
            `FOSR_A_FB_HI: st_d.rdata = st_q.fb_hi;
            `FOSR_A_OC_SEL: st_d.rdata = st_q.oc_sel;
            `FOSR_A_RST_CFG: st_d.rdata = st_q.rst_cfg;
            `FOSR_A_RST_SEL_LO: st_d.rdata = st_q.rst_sel_lo;
            `FOSR_A_RST_SEL_HI: st_d.rdata = st_q.rst_sel_hi;
            `FOSR_A_PIN_TYPE: st_d.rdata = st_q.pin_type;
            `FOSR_A_LOG_CFG: st_d.rdata = st_q.log_cfg;
            `FOSR_A_CRIT_LO: st_d.rdata = st_q.crit_lo;
            `FOSR_A_CRIT_HI: st_d.rdata = st_q.crit_hi;
            `FOSR_A_CRIT_EXT: st_d.rdata = st_q.crit_ext;
            `FOSR_A_DG_OC: st_d.rdata = st_q.dg_oc;
            `FOSR_A_DG_V: st_d.rdata = st_q.dg_v;
            default: st_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign hold_channel = st_q.dg_cnt != 5'h00;
   assign fault_output_a = st_q.fa_hi[`FOSR_B_POL] ? fa_act : !fa_act;
   assign fault_output_b = st_q.fb_hi[`FOSR_B_POL] ? fb_act : !fb_act;
   assign any_fault_b = !(any_st || fa_act || fb_act || seq2_flt || st_q.oc_st);
   assign overcurrent_alarm_b = !primary_oc_cmp;
   assign sequence_fault_indicator_b = !seq2_flt;
   assign seq_fault_req = seq2_flt || ext_low;
   assign reset_output_b = !(rst_cause || st_q.rst_tmr != 32'h0000_0000);
   // Open-drain only ever pulls low; push-pull drives both levels.
   assign secondary_reset_output_o = !(rst2_cause || st_q.rst2_tmr != 32'h0000_0000);
   assign secondary_reset_output_oe = !st_q.pin_type[`FOSR_B_RST2_PIN] ||
                                      !secondary_reset_output_o;
   assign external_fault_line_o = ext_od ? 1'b0 : !st_q.log_lock;
   assign external_fault_line_oe = ext_od ? st_q.log_lock : 1'b1;
   assign watchdog_timeout_output_b = !watchdog_expired;
   assign watchdog_kick = watchdog_kick_input;
   assign log_start = st_q.log_go;
   assign log_mode = st_q.log_cfg[1:0];
   assign log_locked = st_q.log_lock;

   property p_fb_upper;
      @(posedge clk) disable iff (!rst_b)
      (st_q.fb_hi[0] && st_q.fb_hi[`FOSR_B_OV_EN] && st_q.ov_st[8]) |-> fb_act;
   endproperty
   a_fb_upper: assert property (p_fb_upper) else $error("fault B missed monitor 9");
   property p_fb_pol;
      @(posedge clk) disable iff (!rst_b)
      (!st_q.fb_hi[`FOSR_B_POL] && fb_act) |-> !fault_output_b;
   endproperty
   a_fb_pol: assert property (p_fb_pol) else $error("fault B polarity wrong");
   property p_ovc;
      @(posedge clk) disable iff (!rst_b) primary_oc_cmp |-> !overcurrent_alarm_b;
   endproperty
   a_ovc: assert property (p_ovc) else $error("overcurrent alarm not low");
   property p_mr;
      @(posedge clk) disable iff (!rst_b)
      ($rose(manual_reset_input_b) && !st_q.rst_sel_lo[0]) |-> !reset_output_b ##1 !reset_output_b;
   endproperty
   a_mr: assert property (p_mr) else $error("reset released early");
   property p_force;
      @(posedge clk) disable iff (!rst_b)
      st_q.rst_sel_lo[`FOSR_B_FORCE] |-> (!reset_output_b && !secondary_reset_output_o);
   endproperty
   a_force: assert property (p_force) else $error("forced reset not asserted");
   property p_flag_mask;
      @(posedge clk) disable iff (!rst_b) $rose(st_q.flag_lo[0]) |-> $past(st_q.crit_lo[0]);
   endproperty
   a_flag_mask: assert property (p_flag_mask) else $error("flag set without enable");
   property p_w1c;
      @(posedge clk) disable iff (!rst_b)
      (bus.we && bus.addr == `FOSR_A_FLAG_LO && bus.wdata[0] && !set_lo[0]) |=> !st_q.flag_lo[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");
   property p_ext;
      @(posedge clk) disable iff (!rst_b) ext_low |=> st_q.flag_hi[`FOSR_B_EXT_FLAG];
   endproperty
   a_ext: assert property (p_ext) else $error("external fault flag missing");
   property p_lock;
      @(posedge clk) disable iff (!rst_b) log_start |-> log_locked ##1 !log_start;
   endproperty
   a_lock: assert property (p_lock) else $error("log started without lock");
   property p_dg;
      @(posedge clk) disable iff (!rst_b) $rose(|st_q.ov_st) |-> $past(st_q.dg_cnt) != 5'h00;
   endproperty
   a_dg: assert property (p_dg) else $error("fault without deglitch run");

   c_fault_b: cover property (@(posedge clk) disable iff (!rst_b) $rose(fb_act));
   c_log: cover property (@(posedge clk) disable iff (!rst_b) log_start);
   c_rst2_rel: cover property (@(posedge clk) disable iff (!rst_b)
                               $rose(secondary_reset_output_o));
endmodule : fosr_top

// *** dv/fosr_board_model.sv ***
// Board-side model of the manual reset source and the external fault wire.
// Assumes the bench drives the requests and the block drives the pin enable pair.
`timescale 1ns/1ps
module fosr_board_model (
   input wire logic mr_req,
   input wire logic pull_req,
   input wire logic ext_o,
   input wire logic ext_oe,
   output logic manual_reset_input_b,
   output logic external_fault_line_i
);
   // A request holds the reset input low for as long as it stands.
   assign manual_reset_input_b = ~mr_req;
   // The wire has a pull-up, so it reads high unless some party drives it low.
   assign external_fault_line_i = (pull_req || (ext_oe && !ext_o)) ? 1'b0 : 1'b1;
endmodule : fosr_board_model

// *** dv/tb_fosr_top.sv ***
// Self-checking bench of the fault output and reset block.
// Assumes the register port, conversion port and board model of this directory.
`timescale 1ns/1ps
module tb_fosr_top;
   import fosr_pkg::*;
   logic clk = 0, rst_b = 0, poc = 0, soc = 0, s2a = 0, s12d = 1, wde = 0, kick = 0;
   logic alrt = 0, unl = 0, mr_req = 0, pull_req = 0, mr_b, ext_i;
   logic [3:0] s2slot = 4'h0;
   logic [11:0] s2mask = 12'h000, s12mask = 12'h000, mon_en = 12'hFFF;
   fosr_bus_type bus = '0;
   fosr_conv_type conv = '0;
   logic [7:0] rdata;
   logic [1:0] lmode;
   logic hold, wk, wdo_b, fa, fb, anyf_b, oc_b, sfi_b, rst_o_b, r2_o, r2_oe, ext_o, ext_oe;
   logic sfr, lst, lockd;
   int num_errors = 0, n_compared = 0;
   int n_logs = 0;
   logic [31:0] lfsr_q = 32'hFC75;
   logic [7:0] regs [logic [7:0]];
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (lst) n_logs++;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   fosr_top #(.OC_DG1_CYC(5), .OC_DG2_CYC(10), .OC_DG3_CYC(20), .RST_TMO_BASE_CYC(2)) DUT (
      .clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .conv(conv),
      .monitor_input_en(mon_en), .hold_channel(hold), .primary_oc_cmp(poc),
      .secondary_oc_cmp(soc), .seq2_active(s2a), .seq2_slot(s2slot), .seq2_mask(s2mask),
      .slot12_mask(s12mask), .slot12_delay_done(s12d), .manual_reset_input_b(mr_b),
      .watchdog_expired(wde), .watchdog_kick_input(kick), .watchdog_kick(wk),
      .watchdog_timeout_output_b(wdo_b), .alert_event(alrt), .log_unlock(unl),
      .fault_output_a(fa), .fault_output_b(fb), .any_fault_b(anyf_b),
      .overcurrent_alarm_b(oc_b), .sequence_fault_indicator_b(sfi_b),
      .reset_output_b(rst_o_b), .secondary_reset_output_o(r2_o),
      .secondary_reset_output_oe(r2_oe), .external_fault_line_i(ext_i),
      .external_fault_line_o(ext_o), .external_fault_line_oe(ext_oe), .seq_fault_req(sfr),
      .log_start(lst), .log_mode(lmode), .log_locked(lockd));
   fosr_board_model board (.mr_req(mr_req), .pull_req(pull_req), .ext_o(ext_o),
      .ext_oe(ext_oe), .manual_reset_input_b(mr_b), .external_fault_line_i(ext_i));
   task automatic summarize();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: register read %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: %s is %b expected %b", $time, what, got, exp);
      end
   endtask : chk_pin
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      // Reserved bits of the overcurrent select keep zero, so the model masks them.
      regs[a] = (a == 8'h3A) ? (d & 8'h03) : d;
      @(posedge clk);
      bus.we <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus.re <= 1'b0;
      #1;
      chk_reg(rdata, exp);
   endtask : rd
   task automatic cv(input logic [3:0] ch, input logic out, input int n);
      repeat (n) begin
         @(posedge clk);
         lfsr_q = lfsr_next(lfsr_q);
         conv <= '{valid: 1'b1, ch: ch, result: out ? {2'b11, lfsr_q[7:0]} : 10'h100,
                   ov_lim: 8'h80, uv_lim: 8'h10, ew_lim: 8'h10, ew_is_ov: 1'b0};
      end
      @(posedge clk);
      conv.valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask : cv
   // The cause ends at the current edge; the reset must stay low one edge on, then release.
   task automatic rel_chk();
      @(posedge clk);
      #1;
      chk_pin(rst_o_b, 1'b0, "reset held");
      repeat (3) @(posedge clk);
      #1;
      chk_pin(rst_o_b, 1'b1, "reset released");
   endtask : rel_chk
   initial begin
      #40us;
      num_errors++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h39, 8'h00);
      rd(8'h3A, 8'h00);
      wr(8'h3A, 8'hFF);
      rd(8'h3A, regs[8'h3A]);
      rd(8'hF0, 8'h00);
      repeat (20) begin
         @(posedge clk);
         lfsr_q = lfsr_next(lfsr_q);
         poc <= lfsr_q[0];
         wde <= lfsr_q[1];
         kick <= lfsr_q[2];
         #1;
         chk_pin(oc_b, ~poc, "overcurrent alarm");
         chk_pin(wdo_b, ~wde, "watchdog output");
         chk_pin(wk, kick, "watchdog kick");
      end
      @(posedge clk);
      soc <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_pin(fa, 1'b0, "fault a");
      chk_pin(fb, 1'b0, "fault b");
      wr(8'h3A, 8'h01);
      chk_pin(fb, 1'b1, "fault b");
      wr(8'h3A, 8'h00);
      chk_pin(fa, 1'b1, "fault a");
      soc <= 1'b0;
      wr(8'h38, 8'h01);
      wr(8'h39, 8'h10);
      for (int k = 0; k < 4; k++) begin
         wr(8'h74, 8'(k << 5));
         cv(4'h0, 1'b1, (2 << k) - 1);
         chk_pin(fb, 1'b1, "fault b early");
         chk_pin(hold, 1'b1, "channel hold");
         cv(4'h0, 1'b1, 1);
         chk_pin(fb, 1'b0, "fault b");
         chk_pin(anyf_b, 1'b0, "any fault");
         cv(4'h0, 1'b0, 1);
         chk_pin(fb, 1'b1, "fault b cleared");
      end
      wr(8'h74, 8'h00);
      wr(8'h38, 8'h00);
      wr(8'h6F, 8'h01);
      wr(8'h39, 8'h11);
      cv(4'h8, 1'b1, 2);
      chk_pin(fb, 1'b0, "fault b upper");
      chk_pin(lockd, 1'b1, "log lock");
      wr(8'h39, 8'h91);
      chk_pin(fb, 1'b1, "fault b high");
      wr(8'h39, 8'h81);
      chk_pin(fb, 1'b0, "fault b cause off");
      cv(4'h8, 1'b0, 1);
      rd(8'h1B, 8'h00);
      rd(8'h1C, 8'h01);
      wr(8'h1C, 8'h01);
      rd(8'h1C, 8'h00);
      wr(8'h3C, 8'h01);
      chk_pin(rst_o_b, 1'b0, "forced reset");
      chk_pin(r2_o, 1'b0, "forced secondary reset");
      chk_pin(r2_oe, 1'b1, "secondary reset drive");
      wr(8'h3C, 8'h00);
      rel_chk();
      @(posedge clk);
      mr_req <= 1'b1;
      @(posedge clk);
      #1;
      chk_pin(rst_o_b, 1'b0, "manual reset");
      mr_req <= 1'b0;
      rel_chk();
      // The earlier critical fault left the log locked; free it so the pin is released.
      @(posedge clk);
      unl <= 1'b1;
      @(posedge clk);
      unl <= 1'b0;
      wr(8'h42, 8'h08);
      wr(8'h72, 8'h20);
      wr(8'h6D, 8'h04);
      chk_pin(ext_oe, 1'b0, "external line released");
      pull_req <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_pin(sfr, 1'b1, "fault request");
      chk_pin(lockd, 1'b1, "log lock");
      pull_req <= 1'b0;
      @(posedge clk);
      unl <= 1'b1;
      alrt <= 1'b1;
      @(posedge clk);
      unl <= 1'b0;
      alrt <= 1'b0;
      rd(8'h1C, 8'hA0);
      chk_pin(lockd, 1'b0, "log unlocked");
      wr(8'h1C, 8'hA0);
      rd(8'h1C, 8'h00);
      wr(8'h42, 8'h00);
      wr(8'h6E, 8'h04);
      s2mask <= 12'h004;
      s2slot <= 4'h5;
      s2a <= 1'b1;
      cv(4'h2, 1'b1, 2);
      chk_pin(sfi_b, 1'b0, "sequence fault");
      chk_pin(sfr, 1'b1, "sequence request");
      chk_pin(r2_o, 1'b0, "secondary_reset_output in sequence");
      chk_pin(ext_o, 1'b0, "external fault driven");
      rd(8'h1D, 8'h05);
      s2a <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk_pin(r2_o, 1'b0, "critical monitor secondary_reset_output");
      chk_pin(sfi_b, 1'b1, "sequence fault idle");
      cv(4'h2, 1'b0, 1);
      chk_pin(r2_o, 1'b0, "secondary_reset_output timeout");
      repeat (3) @(posedge clk);
      #1;
      chk_pin(r2_o, 1'b1, "secondary_reset_output released");
      wr(8'h42, 8'h02);
      chk_pin(r2_oe, 1'b0, "secondary_reset_output open drain idle");
      wr(8'h3B, 8'h01);
      wr(8'h3C, 8'h02);
      mon_en <= 12'hFFE;
      cv(4'h0, 1'b1, 2);
      chk_pin(hold, 1'b0, "disabled monitor");
      chk_pin(r2_o, 1'b1, "disabled monitor secondary_reset_output");
      mon_en <= 12'hFFF;
      cv(4'h0, 1'b1, 2);
      chk_pin(r2_o, 1'b0, "selected monitor secondary_reset_output");
      chk_pin(r2_oe, 1'b1, "secondary_reset_output open drain low");
      chk_pin(anyf_b, 1'b0, "any fault");
      cv(4'h0, 1'b0, 1);
      wr(8'h6D, 8'h07);
      chk_reg({6'h00, lmode}, 8'h03);
      chk_pin(n_logs == 3, 1'b1, "log start count");
      summarize();
   end
endmodule : tb_fosr_top
